//--- common/cis_pkg.sv
// constants and an address-window helper shared by both ends of the cpu interrupt link
package cis_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_STATUS   = 32'hfff8_4000;
  localparam logic [31:0] ADDR_ENABLE   = 32'hfff8_4004;
  localparam logic [31:0] ADDR_SOFT     = 32'hfff8_4014;
  localparam logic [31:0] ADDR_CTRL     = 32'hfff8_4100;
  localparam logic [31:0] ADDR_IRQ_VIEW = 32'hfff8_4104;
  // device window: 32 bytes starting at the status register
  localparam int          DEV_WIN_LSB   = 5;

  // ----------------------------------------------------------------
  // status / enable bit positions
  // ----------------------------------------------------------------
  localparam int POS_POWER_FAIL        = 30;
  localparam int POS_PARITY_ERROR      = 29;
  localparam int POS_COUNTER_IO        = 21;
  localparam int POS_KEYBOARD          = 19;
  localparam int POS_TWIN_SERIAL       = 18;
  localparam int POS_PARALLEL_PORT     = 17;
  localparam int POS_LAN               = 15;
  localparam int POS_DISK_BUS          = 14;
  localparam int POS_DMA_COUNT_DONE    = 13;
  localparam int POS_DMA_WP_FAULT      = 12;
  localparam int POS_DMA_VALID_FLAG    = 11;
  localparam int POS_GRAPHICS          = 10;
  localparam int POS_SOFT              = 9;
  localparam int POS_SOFT_TRIGGER_BIT  = 0;
  localparam int POS_CTRL_GLOBAL_EN    = 0;

  // defined status bits, and those fed by peripherals
  localparam logic [31:0] DEFINED_MASK = 32'h602e_fe00;
  localparam logic [31:0] PERIPH_MASK  = 32'h602e_fc00;
  localparam logic [31:0] NMI_MASK     = 32'h4000_0000;

  // ----------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------
  localparam logic [31:0] ENABLE_RESET     = 32'h0000_0000;
  localparam logic        GLOBAL_EN_RESET  = 1'b1;
  localparam int          WORD_W           = 32;
  localparam int          SYNC_STAGES      = 2;

  function automatic logic in_dev_window(input logic [31:0] a);
    return a[31:DEV_WIN_LSB] == ADDR_STATUS[31:DEV_WIN_LSB];
  endfunction
endpackage

//--- common/cis_link_if.sv
// link between the interrupt collector and its cpu-side partner
`timescale 1ns/1ps
interface cis_link_if;
  logic [31:0] req_lines;
  logic        reg_req;
  logic        reg_wr;
  logic [31:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_ack;
  logic [31:0] reg_rdata;
  logic        global_en;
  logic        cpu_int;

  modport device (
    input  req_lines, reg_req, reg_wr, reg_addr, reg_wdata, global_en,
    output reg_ack, reg_rdata, cpu_int
  );
  modport partner (
    output req_lines, reg_req, reg_wr, reg_addr, reg_wdata, global_en,
    input  reg_ack, reg_rdata, cpu_int
  );
endinterface // cis_link_if

//--- hdl/cis_collector.sv
// interrupt collector: status, enable mask and software trigger
// ------------------------------------------------------------------
// Notes on behaviour
// - registers are 32-bit words, whole-word access only
// - status, enable, trigger decoded at fixed addresses
// - status bits follow present request levels
// - reset does not directly change status bits; here reset clears the synchronizer, so peripheral bits read 0 until it refills
// - software clears interrupts at the peripheral only
// - enable bits match status bit positions
// - power fail bit 30, parity bit 29
// - counter/io bit 21, keyboard bit 19
// - twin serial bit 18, parallel port bit 17
// - lan bit 15, disk bus bit 14
// - dma done 13, write protect 12, valid 11
// - graphics bit 10, software request bit 9
// - software writes zero to reserved enable bits
// - enable 1 allows, 0 masks each source except power fail
// - power fail ignores its enable bit
// - global disable also blocks power fail
// - reset clears every enable bit
// - software alone decides priority
// - interrupt is OR of status AND enable (power fail unmasked), gated by global enable
// - trigger bit 0 drives status bit 9
// - reset leaves trigger bit; software clears it
// ------------------------------------------------------------------
`timescale 1ns/1ps
module cis_collector #(
  parameter int DATA_W = 32
) (
  // clock, reset, enable
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  // link
  cis_link_if.device link
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (DATA_W != cis_pkg::WORD_W) begin : g_bad_width
    $error("cis_collector: only 32-bit data is supported");
  end

  typedef struct packed {
    logic [31:0] meta;
    logic [31:0] sync;
    logic [31:0] enable_mask_reg;
    logic        ack;
    logic [31:0] rdata;
  } cis_dev_state_t;

  cis_dev_state_t st_ff;
  cis_dev_state_t nxt_st;
  logic           soft_trigger_bit_ff;
  logic           nxt_soft_trigger_bit;
  logic [31:0]    pending_status_reg;
  logic [31:0]    gate_mask;
  logic           wr_en;
  logic           wr_soft;

  // ----------------------------------------------------------------
  // status and interrupt line
  // ----------------------------------------------------------------
  always_comb begin
    pending_status_reg = st_ff.sync & cis_pkg::PERIPH_MASK;
    pending_status_reg[cis_pkg::POS_SOFT] = soft_trigger_bit_ff;
    // power fail passes whatever its stored enable bit says
    gate_mask = st_ff.enable_mask_reg | cis_pkg::NMI_MASK;
  end

  assign link.cpu_int = link.global_en &
                        (|(pending_status_reg & gate_mask));
  assign link.reg_ack   = st_ff.ack;
  assign link.reg_rdata = st_ff.rdata;

  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st      = st_ff;
    wr_en       = link.reg_req & link.reg_wr &
                  (link.reg_addr == cis_pkg::ADDR_ENABLE);
    wr_soft     = link.reg_req & link.reg_wr &
                  (link.reg_addr == cis_pkg::ADDR_SOFT);
    nxt_soft_trigger_bit = soft_trigger_bit_ff;
    // only the second stage is ever read
    nxt_st.meta = link.req_lines & cis_pkg::PERIPH_MASK;
    nxt_st.sync = st_ff.meta;
    nxt_st.ack  = link.reg_req;
    nxt_st.rdata = '0;
    if (wr_en) begin
      // reserved bits are dropped even if software sets them
      nxt_st.enable_mask_reg = link.reg_wdata &
                               cis_pkg::DEFINED_MASK;
    end
    if (wr_soft) begin
      nxt_soft_trigger_bit =
        link.reg_wdata[cis_pkg::POS_SOFT_TRIGGER_BIT];
    end
    // writes to status are ignored: causes clear at the source
    if (link.reg_req && !link.reg_wr &&
        link.reg_addr == cis_pkg::ADDR_STATUS) begin
      nxt_st.rdata = pending_status_reg;
    end
    // enable and trigger reads, and unmapped reads, give zero
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff.meta            <= '0;
      st_ff.sync            <= '0;
      st_ff.enable_mask_reg <= cis_pkg::ENABLE_RESET;
      st_ff.ack             <= 1'b0;
      st_ff.rdata           <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // kept out of reset on purpose: software must clear it after boot
  always_ff @(posedge hclk) begin
    if (ce) begin
      soft_trigger_bit_ff <= nxt_soft_trigger_bit;
    end
  end
endmodule // cis_collector

//--- hdl/cis_cpu_side.sv
// cpu-side partner: ahb-lite slave, request forwarding, global enable
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module cis_cpu_side #(
  parameter int DATA_W = 32
) (
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // peripheral requests and processor line
  input  wire logic [31:0] periph_req,
  output logic             cpu_irq,
  // link
  cis_link_if.partner      link
);
  if (DATA_W != cis_pkg::WORD_W) begin : g_bad_width
    $error("cis_cpu_side: only 32-bit data is supported");
  end

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10,
    ST_DONE  = 2'b11
  } cis_phase_t;

  typedef struct packed {
    cis_phase_t  phase;
    logic        own_wr;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] rdata;
    logic        global_en;
  } cis_host_state_t;

  cis_host_state_t st_ff;
  cis_host_state_t nxt_st;
  logic            take;

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  // peripherals clear their own causes; no clear path exists here
  assign link.req_lines = periph_req & cis_pkg::PERIPH_MASK;
  assign link.reg_req   = (st_ff.phase == ST_ISSUE);
  assign link.reg_wr    = st_ff.wr;
  assign link.reg_addr  = st_ff.addr;
  assign link.reg_wdata = hwdata;
  assign link.global_en = st_ff.global_en;
  // priority among sources is left to software reading status
  assign cpu_irq        = link.cpu_int;
  assign hreadyout      = (st_ff.phase == ST_IDLE) ||
                          (st_ff.phase == ST_DONE);
  assign hresp          = 1'b0;
  assign hrdata         = st_ff.rdata;

  // ----------------------------------------------------------------
  // bus sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    take   = hsel & htrans[1] & hready;
    nxt_st.own_wr = 1'b0;
    if (st_ff.own_wr && st_ff.addr == cis_pkg::ADDR_CTRL) begin
      nxt_st.global_en = hwdata[cis_pkg::POS_CTRL_GLOBAL_EN];
    end
    case (st_ff.phase)
      ST_ISSUE: nxt_st.phase = ST_WAIT;
      ST_WAIT: begin
        if (link.reg_ack) begin
          nxt_st.rdata = link.reg_rdata;
          nxt_st.phase = ST_DONE;
        end
      end
      default: nxt_st.phase = ST_IDLE;
    endcase
    if (take && hreadyout) begin
      nxt_st.addr  = haddr;
      nxt_st.wr    = hwrite;
      nxt_st.rdata = '0;
      if (cis_pkg::in_dev_window(haddr)) begin
        nxt_st.phase = ST_ISSUE;
      end else begin
        nxt_st.phase  = ST_IDLE;
        nxt_st.own_wr = hwrite;
        if (!hwrite && haddr == cis_pkg::ADDR_CTRL) begin
          nxt_st.rdata[cis_pkg::POS_CTRL_GLOBAL_EN] = st_ff.global_en;
        end
        if (!hwrite && haddr == cis_pkg::ADDR_IRQ_VIEW) begin
          nxt_st.rdata[0] = link.cpu_int;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff.phase     <= ST_IDLE;
      st_ff.own_wr    <= 1'b0;
      st_ff.wr        <= 1'b0;
      st_ff.addr      <= '0;
      st_ff.rdata     <= '0;
      st_ff.global_en <= cis_pkg::GLOBAL_EN_RESET;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end
endmodule // cis_cpu_side

//--- verif/cis_monitor.sv
// concurrent checks on the link between the two collector ends
`timescale 1ns/1ps
module cis_monitor (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // link
  input wire logic [31:0] req_lines,
  input wire logic        reg_req,
  input wire logic        reg_wr,
  input wire logic [31:0] reg_addr,
  input wire logic        reg_ack,
  input wire logic [31:0] reg_rdata,
  input wire logic        global_en,
  input wire logic        cpu_int
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_st;
  logic rd_wo;
  assign rd_st = reg_req && !reg_wr && reg_addr == cis_pkg::ADDR_STATUS;
  assign rd_wo = reg_req && !reg_wr &&
                 (reg_addr == cis_pkg::ADDR_ENABLE ||
                  reg_addr == cis_pkg::ADDR_SOFT);
  // --------
  // checks
  // --------
  ack_after_req_a: assert property (
    reg_req |=> reg_ack) else $error("no ack after request");
  ack_has_req_a: assert property (
    reg_ack |-> $past(reg_req)) else $error("ack without request");
  idle_rdata_a: assert property (
    !reg_ack |-> reg_rdata == 32'h0) else $error("read data outside ack");
  wo_read_zero_a: assert property (
    rd_wo |=> reg_rdata == 32'h0) else $error("write-only read not zero");
  status_rsvd_a: assert property (
    rd_st |=> (reg_rdata & ~cis_pkg::DEFINED_MASK) == 32'h0)
    else $error("reserved status bit set");
  status_level_a: assert property (
    rd_st && $stable(req_lines) && req_lines == $past(req_lines, 2) &&
    req_lines == $past(req_lines, 3) |=>
    (reg_rdata & cis_pkg::PERIPH_MASK) ==
    ($past(req_lines) & cis_pkg::PERIPH_MASK))
    else $error("status differs from request levels");
  global_gate_a: assert property (
    !global_en |-> !cpu_int) else $error("interrupt while globally off");
  nmi_pass_a: assert property (
    req_lines[30] [*4] ##0 global_en |-> cpu_int)
    else $error("power fail not passed");
  cover property (rd_st);
  cover property (reg_req && reg_wr);
  cover property (!global_en && req_lines[30]);
endmodule // cis_monitor

//--- verif/cpu_interrupt_status_enable_tb.sv
// self-checking bench for the two collector ends over ahb-lite
`timescale 1ns/1ps
module cpu_interrupt_status_enable_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, periph_req, rd;
  int          err_count, n_tests;
  int          pos [12] = '{30, 29, 21, 19, 18, 17, 15, 14, 13, 12, 11, 10};
  cis_link_if lnk ();
  cis_collector u_cis_collector (.hclk(hclk), .hresetn(hresetn),
    .ce(1'b1), .link(lnk));
  cis_cpu_side u_cis_cpu_side (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .periph_req(periph_req), .cpu_irq(cpu_irq), .link(lnk));
  cis_monitor u_cis_monitor (.hclk(hclk), .hresetn(hresetn),
    .req_lines(lnk.req_lines), .reg_req(lnk.reg_req), .reg_wr(lnk.reg_wr),
    .reg_addr(lnk.reg_addr), .reg_ack(lnk.reg_ack),
    .reg_rdata(lnk.reg_rdata), .global_en(lnk.global_en),
    .cpu_int(lnk.cpu_int));
  always #2.5 hclk = ~hclk;
  // ------------
  // bus tasks
  // ------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    ahb(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic irq(input logic e);
    rchk("irq view", cis_pkg::ADDR_IRQ_VIEW, {31'h0, e});
    chk("cpu_irq", {31'h0, e}, {31'h0, cpu_irq});
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    report_and_stop;
  end
  initial begin
    hclk = 0;
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'b010;
    hwdata = 0;
    periph_req = 0;
    err_count = 0;
    n_tests = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("enable read", cis_pkg::ADDR_ENABLE, 32'h0);
    rchk("trigger read", cis_pkg::ADDR_SOFT, 32'h0);
    rchk("unmapped", 32'hfff8_4018, 32'h0);
    rchk("ctrl reset", cis_pkg::ADDR_CTRL, 32'h1);
    wr(cis_pkg::ADDR_SOFT, 32'h0);
    // unused request lines are driven high to show they are ignored
    foreach (pos[i]) begin
      periph_req <= (32'h1 << pos[i]) | 32'h9fd1_03ff;
      repeat (4) @(posedge hclk);
      rchk("status", cis_pkg::ADDR_STATUS, 32'h1 << pos[i]);
      irq(pos[i] == 30);
      wr(cis_pkg::ADDR_ENABLE, 32'h602e_fe00 & ~(32'h1 << pos[i]));
      irq(pos[i] == 30);
      wr(cis_pkg::ADDR_ENABLE, 32'h1 << pos[i]);
      irq(1'b1);
      wr(cis_pkg::ADDR_ENABLE, 32'h0);
    end
    wr(cis_pkg::ADDR_STATUS, 32'h0);
    rchk("status kept", cis_pkg::ADDR_STATUS, 32'h400);
    periph_req <= 32'h4000_0000;
    repeat (4) @(posedge hclk);
    irq(1'b1);
    wr(cis_pkg::ADDR_CTRL, 32'h0);
    irq(1'b0);
    wr(cis_pkg::ADDR_CTRL, 32'h1);
    periph_req <= 32'h0;
    repeat (4) @(posedge hclk);
    wr(cis_pkg::ADDR_SOFT, 32'h1);
    rchk("soft status", cis_pkg::ADDR_STATUS, 32'h200);
    wr(cis_pkg::ADDR_ENABLE, 32'h200);
    irq(1'b1);
    wr(cis_pkg::ADDR_SOFT, 32'h0);
    rchk("soft clear", cis_pkg::ADDR_STATUS, 32'h0);
    irq(1'b0);
    wr(cis_pkg::ADDR_SOFT, 32'h1);
    wr(cis_pkg::ADDR_ENABLE, 32'h400);
    periph_req <= 32'h400;
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rchk("status after reset", cis_pkg::ADDR_STATUS, 32'h600);
    irq(1'b0);
    report_and_stop;
  end
endmodule // cpu_interrupt_status_enable_tb
